// [hw/cell_link_phy_config.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cell_link_cfg.svh"

module cell_link_phy_config
  import cell_link_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] sb_data,
  input wire logic sb_valid,
  output logic sb_ready,
  output logic [15:0] tx_phy_data_lines,
  output logic [1:0] tx_phy_parity_lines,
  output logic tx_phy_valid,
  output logic tx_phy_soc,
  input wire logic [2:0] hdlc_rx_lines,
  input wire logic [15:0] rx_phy_data_lines,
  input wire logic [1:0] rx_phy_parity_lines,
  input wire logic rx_phy_valid,
  output logic rx_parity_error,
  output logic irq
);

  // ----------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------
  logic [31:0] cfg_q;
  logic [31:0] lsel_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic [7:0] hec_ctrl_q;
  logic aw_have_q;
  logic w_have_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] bmask;
  logic wr_fire;
  logic [1:0] ev_set;

  assign bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= 12'h000;
      awready_q <= 1'b0;
    end else if (s_axi_awvalid && awready_q) begin
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
      awready_q <= 1'b0;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end else begin
      awready_q <= !aw_have_q && !bvalid_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      wready_q <= 1'b0;
    end else if (s_axi_wvalid && wready_q) begin
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
      wready_q <= 1'b0;
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end else begin
      wready_q <= !w_have_q && !bvalid_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `AXI_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      case (awaddr_q)
        `OFS_TXRX_CFG_SET, `OFS_TXRX_CFG_CLR, `OFS_LINK_SELECT,
        `OFS_EVENT_STATUS, `OFS_EVENT_MASK, `OFS_TX_HEC_CTRL: bresp_q <= `AXI_OKAY;
        default: bresp_q <= `AXI_SLVERR;
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Set/clear pair: one-bits written to the set offset set, to the clear offset clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= `RST_TXRX_CFG;
    end else if (wr_fire && awaddr_q == `OFS_TXRX_CFG_SET) begin
      cfg_q <= cfg_q | (wdata_q & bmask & `WMASK_TXRX_CFG);
    end else if (wr_fire && awaddr_q == `OFS_TXRX_CFG_CLR) begin
      cfg_q <= cfg_q & ~(wdata_q & bmask & `WMASK_TXRX_CFG);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lsel_q <= `RST_LINK_SELECT;
      mask_q <= 2'h0;
      hec_ctrl_q <= `RST_TX_HEC_CTRL;
    end else if (wr_fire) begin
      if (awaddr_q == `OFS_LINK_SELECT) begin
        lsel_q <= (lsel_q & ~(bmask & `WMASK_LINK_SELECT)) | (wdata_q & bmask & `WMASK_LINK_SELECT);
      end
      if (awaddr_q == `OFS_EVENT_MASK && wstrb_q[0]) begin
        mask_q <= wdata_q[1:0];
      end
      if (awaddr_q == `OFS_TX_HEC_CTRL && wstrb_q[0]) begin
        hec_ctrl_q <= wdata_q[7:0];
      end
    end
  end

  // Sticky events: a new event beats a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= 2'h0;
    end else if (wr_fire && awaddr_q == `OFS_EVENT_STATUS && wstrb_q[0]) begin
      status_q <= (status_q & ~wdata_q[1:0]) | ev_set;
    end else begin
      status_q <= status_q | ev_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= `AXI_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= `AXI_OKAY;
      case (s_axi_araddr)
        `OFS_TXRX_CFG_SET, `OFS_TXRX_CFG_CLR: rdata_q <= cfg_q;
        `OFS_LINK_SELECT: rdata_q <= lsel_q;
        `OFS_EVENT_STATUS: rdata_q <= {30'h0, status_q};
        `OFS_EVENT_MASK: rdata_q <= {30'h0, mask_q};
        `OFS_TX_HEC_CTRL: rdata_q <= {24'h0, hec_ctrl_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `AXI_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end else begin
      arready_q <= !rvalid_q;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // ----------------------------------------------------------
  // Effective configuration
  // ----------------------------------------------------------
  logic tx_int;
  logic rx_int;
  logic skip_upper;
  logic tx_cell;
  logic [1:0] eff_extra;
  logic eff_c52;
  logic eff_mod;
  logic eff_hec_dis;
  logic eff_par_full;
  logic tx_w16;

  assign tx_int = lsel_q[`F_TX_INTERNAL];
  assign rx_int = lsel_q[`F_RX_INTERNAL];
  assign skip_upper = tx_int ^ rx_int;
  assign tx_cell = (cfg_q[`F_TX_DEV_HI:`F_TX_DEV_LO] == `DEV_CELL)
                   && (lsel_q[`F_TX_PORT_HI:`F_TX_PORT_LO] != `PORT_UNUSED);
  // no extras in 25 Mb/s mode
  assign eff_extra = (tx_cell && !lsel_q[`F_MODE_25M]) ? cfg_q[`F_TX_EXTRA_HI:`F_TX_EXTRA_LO] : 2'h0;
  assign eff_c52 = tx_cell && cfg_q[`F_TX_C52];
  assign eff_mod = tx_cell && cfg_q[`F_TX_ALIGN_MOD];
  assign eff_hec_dis = tx_cell && cfg_q[`F_TX_HEC_DIS];
  assign eff_par_full = !tx_cell || cfg_q[`F_TX_PAR_FULL];
  assign tx_w16 = !cfg_q[`F_TX_W8];

  // ----------------------------------------------------------
  // Transmit cell assembly
  // ----------------------------------------------------------
  // Layout is frozen at cell start so a mid-cell write cannot tear a cell.
  tx_state_e state_q;
  logic [6:0] pos_q;
  logic [6:0] pos_d;
  logic [6:0] lay_e_q;
  logic lay_c52_q;
  logic lay_hpad_q;
  logic lay_drop_q;
  logic lay_w16_q;
  logic lay_hec_dis_q;
  logic lay_full_q;
  logic [6:0] lay_total_q;
  logic [6:0] base_len;
  logic [6:0] new_total;
  logic new_hpad;
  logic new_drop;
  slot_kind_e kind;
  slot_kind_e kind_next;
  logic slot_done;
  logic [7:0] slot_byte;
  logic emit;
  logic half_q;
  logic [7:0] hi_q;
  logic [15:0] word_q;
  logic [15:0] word_nx;
  logic first_q;

  function automatic slot_kind_e slot_of(input logic [6:0] p, input logic [6:0] e,
                                         input logic c52, input logic hpad);
    slot_kind_e k;
    k = slot_src;
    if (!c52 && p == e + `CELL_HDR_BYTES) begin
      k = slot_hec;
    end else if (hpad && p == e + `CELL_HDR_BYTES + 7'h01) begin
      k = slot_pad;
    end else if (p >= e + `CELL_HDR_BYTES + `CELL_PAYLOAD_BYTES + {6'h0, !c52} + {6'h0, hpad}) begin
      k = slot_pad;
    end
    return k;
  endfunction : slot_of

  assign new_hpad = tx_w16 && !eff_c52 && !(eff_mod && eff_extra != 2'h0);
  // three extras cannot fit: first one is truncated
  assign new_drop = new_hpad && eff_extra == 2'h3;
  // 52-byte cells carry no HEC slot
  assign base_len = {5'h0, eff_extra} + `CELL_HDR_BYTES + `CELL_PAYLOAD_BYTES
                    + {6'h0, !eff_c52} + {6'h0, new_hpad} - {6'h0, new_drop};
  assign new_total = base_len + {6'h0, tx_w16 && base_len[0]} + {6'h0, new_drop};

  assign kind = slot_of(pos_q, lay_e_q, lay_c52_q, lay_hpad_q);
  assign slot_done = (state_q == st_send) && ((kind != slot_src) || (sb_valid && sb_ready));
  assign pos_d = pos_q + 7'h01;
  assign kind_next = slot_of(pos_d, lay_e_q, lay_c52_q, lay_hpad_q);
  // prepended bytes come from the buffer; only a truncated one is dropped
  assign emit = slot_done && !(lay_drop_q && pos_q == 7'h00);

  always_comb begin
    slot_byte = sb_data;
    case (kind)
      slot_hec: slot_byte = lay_hec_dis_q ? 8'h00 : hec_ctrl_q;
      slot_pad: slot_byte = 8'h00;
      default: slot_byte = sb_data;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= st_idle;
      pos_q <= 7'h00;
      sb_ready <= 1'b0;
      lay_e_q <= 7'h00;
      lay_c52_q <= 1'b0;
      lay_hpad_q <= 1'b0;
      lay_drop_q <= 1'b0;
      lay_w16_q <= 1'b0;
      lay_hec_dis_q <= 1'b0;
      lay_full_q <= 1'b1;
      lay_total_q <= 7'h00;
    end else begin
      case (state_q)
        st_idle: begin
          if (sb_valid) begin
            state_q <= st_send;
            pos_q <= 7'h00;
            lay_e_q <= {5'h0, eff_extra};
            lay_c52_q <= eff_c52;
            lay_hpad_q <= new_hpad;
            lay_drop_q <= new_drop;
            lay_w16_q <= tx_w16;
            lay_hec_dis_q <= eff_hec_dis;
            lay_full_q <= eff_par_full;
            lay_total_q <= new_total;
            sb_ready <= 1'b1;
          end
        end
        st_send: begin
          if (slot_done) begin
            if (pos_d == lay_total_q) begin
              state_q <= st_idle;
              sb_ready <= 1'b0;
            end else begin
              pos_q <= pos_d;
              sb_ready <= (kind_next == slot_src);
            end
          end
        end
        default: begin
          state_q <= st_idle;
          sb_ready <= 1'b0;
        end
      endcase
    end
  end

  // 16-bit path: first byte of a pair rides the high lane
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_q <= 1'b0;
      hi_q <= 8'h00;
      word_q <= 16'h0000;
      tx_phy_valid <= 1'b0;
      tx_phy_soc <= 1'b0;
      tx_phy_parity_lines <= 2'h0;
      first_q <= 1'b1;
    end else begin
      tx_phy_valid <= 1'b0;
      if (emit && lay_w16_q && !half_q) begin
        half_q <= 1'b1;
        hi_q <= slot_byte;
      end else if (emit) begin
        half_q <= 1'b0;
        tx_phy_valid <= 1'b1;
        tx_phy_soc <= first_q;
        first_q <= 1'b0;
        if (lay_w16_q) begin
          word_q <= {hi_q, slot_byte};
          // one full-width bit or two per-byte bits
          if (lay_full_q) begin
            tx_phy_parity_lines <= {((^{hi_q, slot_byte}) ^ cfg_q[`F_TX_PAR_ODD]) & !skip_upper,
                                    (^{hi_q, slot_byte}) ^ cfg_q[`F_TX_PAR_ODD]};
          end else begin
            tx_phy_parity_lines <= {((^hi_q) ^ cfg_q[`F_TX_PAR_ODD]) & !skip_upper,
                                    (^slot_byte) ^ cfg_q[`F_TX_PAR_ODD]};
          end
        end else begin
          word_q <= {8'h00, slot_byte};
          tx_phy_parity_lines <= {1'b0, (^slot_byte) ^ cfg_q[`F_TX_PAR_ODD]};
        end
      end
      if (slot_done && pos_d == lay_total_q) begin
        first_q <= 1'b1;
      end
    end
  end

  // Next word formed here so the data lines move with the valid pulse
  always_comb begin
    word_nx = word_q;
    if (emit && !(lay_w16_q && !half_q)) begin
      word_nx = lay_w16_q ? {hi_q, slot_byte} : {8'h00, slot_byte};
    end
  end

  // lines 15 to 13 shared with receive HDLC
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_phy_data_lines <= 16'h0000;
    end else if (rx_int && !tx_int && !cfg_q[`F_RX_W8]) begin
      tx_phy_data_lines <= {hdlc_rx_lines, word_nx[12:0]};
    end else begin
      tx_phy_data_lines <= word_nx;
    end
  end

  // ----------------------------------------------------------
  // Receive parity check
  // ----------------------------------------------------------
  logic rx_used;
  logic rx_frame;
  logic rx_w8;
  logic rx_odd;
  logic rx_err;

  // only known codes on a used port
  assign rx_used = (lsel_q[`F_RX_PORT_HI:`F_RX_PORT_LO] != `PORT_UNUSED)
                   && ((cfg_q[`F_RX_DEV_HI:`F_RX_DEV_LO] == `DEV_FRAME)
                       || (cfg_q[`F_RX_DEV_HI:`F_RX_DEV_LO] == `DEV_CELL));
  assign rx_frame = cfg_q[`F_RX_DEV_HI:`F_RX_DEV_LO] == `DEV_FRAME;
  assign rx_w8 = cfg_q[`F_RX_W8];
  assign rx_odd = cfg_q[`F_RX_PAR_ODD];

  always_comb begin
    rx_err = 1'b0;
    if (rx_w8) begin
      // 8-bit with bit clear uses line one, except frame devices
      if (!cfg_q[`F_RX_PAR_FULL] && !rx_frame) begin
        rx_err = ((^rx_phy_data_lines[7:0]) ^ rx_odd) != rx_phy_parity_lines[1];
      end else begin
        rx_err = ((^rx_phy_data_lines[7:0]) ^ rx_odd) != rx_phy_parity_lines[0];
      end
    end else if (cfg_q[`F_RX_PAR_FULL] && !rx_frame && !skip_upper) begin
      rx_err = ((^rx_phy_data_lines) ^ rx_odd) != rx_phy_parity_lines[1];
    end else begin
      rx_err = (((^rx_phy_data_lines[7:0]) ^ rx_odd) != rx_phy_parity_lines[0])
               || (!skip_upper && (((^rx_phy_data_lines[15:8]) ^ rx_odd) != rx_phy_parity_lines[1]));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_parity_error <= 1'b0;
    end else begin
      rx_parity_error <= rx_phy_valid && cfg_q[`F_RX_PAR_EN] && rx_used && rx_err;
    end
  end

  assign ev_set = {rx_parity_error, tx_phy_valid && tx_phy_soc};

endmodule : cell_link_phy_config

`default_nettype wire

// [hw/cell_link_cfg.svh]
`ifndef CELL_LINK_CFG_SVH
`define CELL_LINK_CFG_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_TXRX_CFG_SET 12'hb58
`define OFS_TXRX_CFG_CLR 12'hb5c
`define OFS_LINK_SELECT 12'hb60
`define OFS_EVENT_STATUS 12'hb64
`define OFS_EVENT_MASK 12'hb68
`define OFS_TX_HEC_CTRL 12'hb6c

// ------------------------------------------------------------
// Reset values and writable masks
// ------------------------------------------------------------
`define RST_TXRX_CFG 32'h78016e00
`define WMASK_TXRX_CFG 32'hf83ffeff
`define RST_LINK_SELECT 32'h00001f1f
`define WMASK_LINK_SELECT 32'h00071f1f
`define RST_TX_HEC_CTRL 8'h00

// ------------------------------------------------------------
// Configuration field positions
// ------------------------------------------------------------
`define F_TX_DEV_HI 31
`define F_TX_DEV_LO 29
`define F_TX_PAR_ODD 28
`define F_TX_W8 27
`define F_TX_EXTRA_HI 21
`define F_TX_EXTRA_LO 20
`define F_TX_ALIGN_MOD 19
`define F_TX_C52 18
`define F_TX_HEC_DIS 17
`define F_TX_PAR_FULL 16
`define F_RX_DEV_HI 15
`define F_RX_DEV_LO 13
`define F_RX_PAR_EN 12
`define F_RX_PAR_ODD 11
`define F_RX_W8 10
`define F_RX_PAR_FULL 9

// Link select register: port addresses, path routing and 25 Mb/s mode
`define F_TX_PORT_HI 4
`define F_TX_PORT_LO 0
`define F_RX_PORT_HI 12
`define F_RX_PORT_LO 8
`define F_TX_INTERNAL 16
`define F_RX_INTERNAL 17
`define F_MODE_25M 18

// Event status / mask bits
`define EV_CELL_SENT 0
`define EV_RX_PAR_ERR 1

// ------------------------------------------------------------
// Codes and cell geometry
// ------------------------------------------------------------
`define DEV_FRAME 3'h1
`define DEV_CELL 3'h3
`define PORT_UNUSED 5'h1f
`define CELL_HDR_BYTES 7'h04
`define CELL_PAYLOAD_BYTES 7'h30
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2

`endif

// [hw/cell_link_pkg.sv]
package cell_link_pkg;

  typedef enum logic [0:0] {
    st_idle = 1'b0,
    st_send = 1'b1
  } tx_state_e;

  typedef enum logic [1:0] {
    slot_src = 2'b00,
    slot_hec = 2'b01,
    slot_pad = 2'b10
  } slot_kind_e;

endpackage : cell_link_pkg

// [testbench/cell_link_phy_config_chk.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module cell_link_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] tx_phy_data_lines,
  input wire logic tx_phy_valid,
  input wire logic tx_phy_soc,
  input wire logic rx_phy_valid,
  input wire logic rx_parity_error,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("bad write response code");
  a_refused_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write accepted while response pending");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  // Lines 15 to 13 may carry the receive controller, so only 12:0 must hold
  a_tx_word_holds: assert property (!tx_phy_valid |-> $stable(tx_phy_data_lines[12:0]))
    else $error("transmit word changed without valid");
  // Check only on a word that arrived
  a_err_has_word: assert property (rx_parity_error |-> $past(rx_phy_valid))
    else $error("parity error without word");
  c_cell_start: cover property (tx_phy_valid && tx_phy_soc);
  c_parity_bad: cover property (rx_parity_error);
  c_irq_up: cover property ($rose(irq));
endmodule : cell_link_chk
bind cell_link_phy_config cell_link_chk chk_u (.*);
`default_nettype wire

// [testbench/phy_far_end.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Far-end PHY
// ----------------------------------------
module phy_far_end (
  input wire logic aclk,
  input wire logic [15:0] tx_phy_data_lines,
  input wire logic [1:0] tx_phy_parity_lines,
  input wire logic tx_phy_valid,
  input wire logic tx_phy_soc,
  input wire logic rx_go,
  input wire logic [15:0] rx_word,
  input wire logic [1:0] rx_par,
  output logic [15:0] rx_phy_data_lines,
  output logic [1:0] rx_phy_parity_lines,
  output logic rx_phy_valid
);
  logic [18:0] words[$];
  initial begin
    rx_phy_data_lines = 16'h0;
    rx_phy_parity_lines = 2'h0;
    rx_phy_valid = 1'h0;
  end
  always @(posedge aclk) begin
    if (tx_phy_valid) words.push_back({tx_phy_soc, tx_phy_parity_lines, tx_phy_data_lines});
  end
  // Idle lines toggle so a stale word is never taken for a fresh one
  always @(posedge aclk) begin
    rx_phy_valid <= rx_go;
    rx_phy_data_lines <= rx_go ? rx_word : ~rx_phy_data_lines;
    rx_phy_parity_lines <= rx_go ? rx_par : ~rx_phy_parity_lines;
  end
endmodule : phy_far_end
`default_nettype wire

// [testbench/cell_link_phy_config_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "cell_link_cfg.svh"
module cell_link_phy_config_tb;
  logic aclk = 1'h0;
  logic aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sb_valid, sb_ready, rx_go;
  logic tx_phy_valid, tx_phy_soc, rx_phy_valid, rx_parity_error, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, tx_phy_parity_lines, rx_phy_parity_lines, rx_par, r;
  logic [15:0] tx_phy_data_lines, rx_phy_data_lines, rx_word, lfsr_q = 16'h387e;
  logic [7:0] sb_data;
  logic [2:0] hdlc_rx_lines;
  logic [7:0] src[$], b[$];
  int errors, checks_done;
  logic [11:0] ra[6] = '{`OFS_TXRX_CFG_SET, `OFS_TXRX_CFG_CLR, `OFS_LINK_SELECT, `OFS_EVENT_STATUS,
    `OFS_EVENT_MASK, `OFS_TX_HEC_CTRL};
  logic [31:0] rv[6] = '{32'h78016e00, 32'h78016e00, `RST_LINK_SELECT, 32'h0, 32'h0, 32'h0};
  // Cases: {25M, other device, 8-bit, full parity, HEC off, 52-byte, align, extras}
  logic [8:0] tc[8] = '{
    9'h060,
    9'h06a,
    9'h071,
    9'h003,
    9'h027,
    9'h038,
    9'h0da,
    9'h162};

  cell_link_phy_config dut_u (.*);
  phy_far_end far_u (.*);

  always #10 aclk = ~aclk;

  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction : rnd

  // Expected byte stream of one cell; three extras in padded mode lose the first
  function automatic void fill(input logic [8:0] c, input logic [7:0] hec);
    int ne, k;
    logic c52, pad;
    ne = (c[7] | c[8]) ? 0 : int'(c[1:0]);
    c52 = c[3] & !c[7];
    pad = !c[6] && !c52 && !(c[2] && !c[7] && ne != 0);
    src.delete();
    b.delete();
    for (k = 0; k < ne + 52; k++) src.push_back(8'(rnd()));
    for (k = (pad && ne == 3) ? 1 : 0; k < ne + 4; k++) b.push_back(src[k]);
    if (!c52) b.push_back((c[4] & !c[7]) ? 8'h00 : hec);
    if (pad) b.push_back(8'h00);
    for (k = ne + 4; k < ne + 52; k++) b.push_back(src[k]);
    if (!c[6] && b.size() % 2 == 1) b.push_back(8'h00);
  endfunction : fill

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic ax(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rq,
      output logic [1:0] rr);
    int n;
    n = 0;
    @(posedge aclk);
    if (w) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
    end
    // Ready comes late on purpose so the slave must hold its answer
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (n == 3) {s_axi_bready, s_axi_rready} <= {w, !w};
    end while (!(w ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready) && n < 200);
    rq = s_axi_rdata;
    rr = w ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    if (n >= 200) chk("bus answer", 32'h0, 32'h1);
  endtask : ax

  task automatic rx_try(input logic [15:0] w, input logic [1:0] p, input logic e);
    @(posedge aclk);
    rx_word <= w;
    rx_par <= p;
    rx_go <= 1'h1;
    @(posedge aclk);
    rx_go <= 1'h0;
    @(posedge aclk);
    #1;
    chk("rx parity error", {31'h0, e}, {31'h0, rx_parity_error});
  endtask : rx_try

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // A run takes some 1.4k cycles; this limit is about seven times that
  initial begin
    #200000;
    errors++;
    stop_test();
  end

  initial begin
    int i, t, n, nw;
    logic [8:0] c;
    logic [7:0] hec;
    logic [15:0] e, mk, w;
    logic [1:0] p, fm;
    logic [2:0] cd;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sb_valid, rx_go} = 8'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sb_data, rx_word, rx_par, hdlc_rx_lines} = 85'h0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    for (i = 0; i < 6; i++) begin
      ax(1'h0, ra[i], 32'h0, q, r);
      chk("reset value", rv[i], q);
    end
    ax(1'h0, 12'hb70, 32'h0, q, r);
    chk("unmapped read", {30'h0, 2'h2}, {q[29:0], r});
    ax(1'h1, 12'hb70, 32'h5, q, r);
    chk("unmapped write", 32'h2, {30'h0, r});
    // Cell formats
    for (t = 0; t < 8; t++) begin
      c = tc[t];
      hec = 8'(rnd());
      ax(1'h1, `OFS_TX_HEC_CTRL, {24'h0, hec}, q, r);
      ax(1'h1, `OFS_TXRX_CFG_CLR, 32'h483f0000, q, r);
      ax(1'h1, `OFS_TXRX_CFG_SET, {1'h0, !c[7], 2'h0, c[6], 5'h0, c[1:0], c[2], c[3], c[4], c[5], 16'h0}, q, r);
      ax(1'h1, `OFS_LINK_SELECT, {13'h0, c[8], 18'h0}, q, r);
      fill(c, hec);
      far_u.words.delete();
      sb_data <= src[0];
      sb_valid <= 1'h1;
      i = 0;
      n = 0;
      while (i < src.size() && n < 500) begin
        @(posedge aclk);
        n++;
        if (sb_ready) begin
          i++;
          if (i < src.size()) sb_data <= src[i];
          else sb_valid <= 1'h0;
        end
      end
      nw = c[6] ? b.size() : b.size() / 2;
      repeat (20) @(posedge aclk);
      chk("tx word count", nw, far_u.words.size());
      mk = c[6] ? 16'h00ff : 16'hffff;
      for (i = 0; i < nw; i++) begin
        e = c[6] ? {8'h0, b[i]} : {b[2 * i], b[2 * i + 1]};
        p = c[6] ? {1'h0, ~^e[7:0]} : ((c[5] | c[7]) ? {2{~^e}} : {~^e[15:8], ~^e[7:0]});
        chk("tx word", {13'h0, i == 0, p, e & mk},
          {13'h0, far_u.words[i][18:16], far_u.words[i][15:0] & mk});
      end
    end
    // Receive parity: {bad, enable, odd, 8-bit, full}
    ax(1'h1, `OFS_LINK_SELECT, 32'h0, q, r);
    for (t = 0; t < 32; t++) begin
      ax(1'h1, `OFS_TXRX_CFG_CLR, 32'h1e00, q, r);
      ax(1'h1, `OFS_TXRX_CFG_SET, {19'h0, t[3:0], 9'h0}, q, r);
      w = rnd();
      fm = t[1] ? (t[0] ? 2'h1 : 2'h2) : (t[0] ? 2'h2 : 2'h1);
      p = t[1] ? {2{^w[7:0] ^ t[2]}} : (t[0] ? {2{^w ^ t[2]}} : {^w[15:8] ^ t[2], ^w[7:0] ^ t[2]});
      rx_try(w, p ^ (t[4] ? fm : 2'h0), t[3] & t[4]);
    end
    // Device codes, then an unused port
    ax(1'h1, `OFS_TXRX_CFG_CLR, 32'h1e00, q, r);
    ax(1'h1, `OFS_TXRX_CFG_SET, 32'h1600, q, r);
    for (t = 0; t < 9; t++) begin
      cd = (t == 8) ? 3'h3 : t[2:0];
      ax(1'h1, `OFS_TXRX_CFG_CLR, 32'he000, q, r);
      ax(1'h1, `OFS_TXRX_CFG_SET, {16'h0, cd, 13'h0}, q, r);
      if (t == 8) ax(1'h1, `OFS_LINK_SELECT, 32'h1f00, q, r);
      w = rnd();
      rx_try(w, {2{~^w[7:0]}}, (cd == 3'h1 || cd == 3'h3) && t < 8);
    end
    // Receive HDLC lines borrow transmit lines 15 to 13
    ax(1'h1, `OFS_LINK_SELECT, 32'h20000, q, r);
    hdlc_rx_lines <= 3'h5;
    ax(1'h1, `OFS_TXRX_CFG_CLR, 32'h400, q, r);
    chk("hdlc lines", 32'h5, {29'h0, tx_phy_data_lines[15:13]});
    ax(1'h1, `OFS_TXRX_CFG_SET, 32'h400, q, r);
    chk("tx upper lines", 32'h0, {29'h0, tx_phy_data_lines[15:13]});
    // Interrupt raise, clear, mask
    ax(1'h1, `OFS_LINK_SELECT, 32'h0, q, r);
    ax(1'h0, `OFS_EVENT_STATUS, 32'h0, q, r);
    chk("status events", 32'h3, q);
    ax(1'h1, `OFS_EVENT_STATUS, 32'h3, q, r);
    ax(1'h1, `OFS_EVENT_MASK, 32'h2, q, r);
    rx_try(16'h0001, 2'h0, 1'h1);
    repeat (2) @(posedge aclk);
    #1;
    chk("irq raised", 32'h1, {31'h0, irq});
    ax(1'h1, `OFS_EVENT_STATUS, 32'h2, q, r);
    repeat (2) @(posedge aclk);
    #1;
    chk("irq cleared", 32'h0, {31'h0, irq});
    ax(1'h1, `OFS_EVENT_MASK, 32'h0, q, r);
    rx_try(16'h0001, 2'h0, 1'h1);
    repeat (2) @(posedge aclk);
    #1;
    chk("irq masked", 32'h0, {31'h0, irq});
    ax(1'h0, `OFS_EVENT_STATUS, 32'h0, q, r);
    chk("status sticky", 32'h2, q);
    stop_test();
  end
endmodule : cell_link_phy_config_tb
`default_nettype wire
